/* design/mtw_top.sv */
// Translation decision logic: bypass, windows, translation cache, aborts
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ns
`include "mtw_cfg.svh"
module mtw_top (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // Register port
  input  wire logic [`MTW_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_we,
  input  wire logic                   reg_re,
  output logic [31:0]                 reg_rdata,
  // Access request from the core
  input  wire logic                   acc_req,
  input  wire logic [31:0]            acc_la,
  input  wire logic [2:0]             space_code_bits,
  input  wire logic                   acc_read,
  input  wire logic                   acc_rmw,
  input  wire logic                   acc_cache_hit,
  input  wire logic                   acc_follow,
  input  wire logic                   translation_disable_in,
  // Access answer
  output logic [31:0]                 phys_addr,
  output logic                        address_strobe_n,
  output logic                        cache_inhibit_out_n,
  output logic                        acc_abort,
  output logic                        acc_berr,
  output logic                        acc_done,
  output logic                        acc_retry,
  output logic                        busy,
  // Table walker
  output logic                        walk_req,
  output logic [31:0]                 walk_la,
  output logic [2:0]                  walk_fc,
  output logic                        walk_set_mod,
  input  wire logic                   walk_done,
  input  wire logic                   walk_berr,
  input  wire logic                   walk_ci,
  input  wire logic                   walk_wp,
  input  wire logic                   walk_mod,
  input  wire logic [23:0]            walk_pa
);
  import mtw_pkg::*;

  // ************************************************************
  // Decode functions
  // ************************************************************

  // Window match on space code, top byte and direction
  function automatic logic win_match(
    input logic [31:0] w,
    input logic [31:0] la,
    input logic [2:0]  fc,
    input logic        rd,
    input logic        rmw
  );
    logic [7:0] amask;
    logic [2:0] fmask;
    logic       ok;
    amask = w[`MTW_W_MASK_HI:`MTW_W_MASK_LO];
    fmask = w[`MTW_W_FCM_HI:`MTW_W_FCM_LO];
    ok = w[`MTW_W_EN];
    ok = ok & (((la[31:24] ^ w[`MTW_W_BASE_HI:`MTW_W_BASE_LO])
               & ~amask) == 8'h00);
    ok = ok & (((fc ^ w[`MTW_W_FCB_HI:`MTW_W_FCB_LO])
               & ~fmask) == 3'h0);
    if (!w[`MTW_W_RWM])
    begin
      ok = ok & (rd == w[`MTW_W_RWSEL]);
      ok = ok & ~rmw;
    end
    return ok;
  endfunction

  // Tag compare with page-size masking of the low page bits
  function automatic logic tag_hit(
    input logic [`MTW_TAG_W-1:0] t,
    input logic [31:0]           la,
    input logic [2:0]            fc,
    input logic [23:0]           pmask
  );
    return t[`MTW_T_V]
         & (t[`MTW_T_FC_HI:`MTW_T_FC_LO] == fc)
         & (((t[23:0] ^ la[31:8]) & pmask) == 24'h00_0000);
  endfunction

  // ************************************************************
  // State and lookup
  // ************************************************************

  mtw_state_s_t          s_r;
  mtw_state_s_t          s_nxt;
  logic [23:0]           pg_mask;
  logic [3:0]            pg_ign;
  logic [`MTW_ENTRIES-1:0] hit_vec;
  logic [`MTW_ENTRIES-1:0] whit_vec;

  // Page mask from the page size field
  always_comb
  begin
    if (s_r.tc[`MTW_TC_PS_HI:`MTW_TC_PS_LO] > `MTW_PS_MIN)
      pg_ign = s_r.tc[`MTW_TC_PS_HI:`MTW_TC_PS_LO] - `MTW_PS_MIN;
    else
      pg_ign = 4'h0;
    pg_mask = 24'hFF_FFFF << pg_ign;
  end

  // Parallel tag compare of every entry
  genvar gi;
  generate
    for (gi = 0; gi < `MTW_ENTRIES; gi++)
    begin : g_cmp
      assign hit_vec[gi]  = tag_hit(s_r.tag[gi], acc_la,
                                    space_code_bits, pg_mask);
      assign whit_vec[gi] = tag_hit(s_r.tag[gi], s_r.wla,
                                    s_r.wfc, pg_mask);
    end
  endgenerate

  // ************************************************************
  // Next-state logic
  // ************************************************************

  always_comb
  begin
    logic                   m0;
    logic                   m1;
    logic                   hit;
    logic [4:0]             hidx;
    logic [4:0]             vic;
    logic                   vfound;
    logic                   wr_acc;
    logic [`MTW_DAT_W-1:0]  ent;
    logic [`MTW_ENTRIES-1:0] nh;
    m0     = 1'b0;
    m1     = 1'b0;
    hit    = 1'b0;
    hidx   = 5'h00;
    vic    = 5'h00;
    vfound = 1'b0;
    ent    = '0;
    nh     = '0;
    wr_acc = ~acc_read | acc_rmw;
    s_nxt  = s_r;
    // Pulses fall by default
    s_nxt.as_n  = 1'b1;
    s_nxt.abort = 1'b0;
    s_nxt.berr  = 1'b0;
    s_nxt.done  = 1'b0;
    s_nxt.retry = 1'b0;

    // Register writes and reads
    if (reg_we)
    begin
      unique case (reg_addr)
        `MTW_OFS_TC:  s_nxt.tc  = reg_wdata;
        `MTW_OFS_TW0: s_nxt.tw0 = reg_wdata;
        `MTW_OFS_TW1: s_nxt.tw1 = reg_wdata;
        `MTW_OFS_CMD:
        begin
          if (reg_wdata[`MTW_CMD_FLUSH])
          begin
            for (int i = 0; i < `MTW_ENTRIES; i++)
              s_nxt.tag[i][`MTW_T_V] = 1'b0;
            s_nxt.hist = '0;
          end
        end
        default: ;
      endcase
    end
    s_nxt.rdata = `MTW_ZERO32;
    if (reg_re)
    begin
      unique case (reg_addr)
        `MTW_OFS_TC:   s_nxt.rdata = s_r.tc;
        `MTW_OFS_TW0:  s_nxt.rdata = s_r.tw0;
        `MTW_OFS_TW1:  s_nxt.rdata = s_r.tw1;
        `MTW_OFS_STAT:
        begin
          s_nxt.rdata[2:0]          = s_r.path;
          s_nxt.rdata[`MTW_ST_BUSY] = (s_r.st == MTW_WALK);
          s_nxt.rdata[`MTW_ST_BERR] = s_r.last_berr;
        end
        default: s_nxt.rdata = `MTW_ZERO32;
      endcase
    end

    // First matching cache entry
    for (int i = `MTW_ENTRIES - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        hit  = 1'b1;
        hidx = 5'(i);
      end
    end

    unique case (s_r.st)
      MTW_IDLE:
      begin
        if (acc_req)
        begin
          m0 = win_match(s_r.tw0, acc_la, space_code_bits,
                         acc_read, acc_rmw);
          m1 = win_match(s_r.tw1, acc_la, space_code_bits,
                         acc_read, acc_rmw);
          s_nxt.pa      = acc_la;
          s_nxt.ci_n    = 1'b1;
          s_nxt.hold_ok = 1'b0;
          if (acc_follow && s_r.hold_ok)
          begin
            // Reuse upper bits and mode of the first cycle
            s_nxt.pa      = {s_r.hold_pa[31:2], acc_la[1:0]};
            s_nxt.ci_n    = ~s_r.hold_ci;
            s_nxt.as_n    = 1'b0;
            s_nxt.hold_ok = 1'b1;
            s_nxt.path    = MTW_P_SEQ;
          end
          else if (space_code_bits == `MTW_CPU_FC)
          begin
            s_nxt.as_n = 1'b0;
            s_nxt.path = MTW_P_CPU;
          end
          else if (acc_read && acc_cache_hit)
          begin
            s_nxt.done = 1'b1;
            s_nxt.path = MTW_P_CACHE;
          end
          else if (m0 || m1)
          begin
            // Direct mapping, no protection check
            s_nxt.as_n = 1'b0;
            s_nxt.ci_n = ~((m0 & s_r.tw0[`MTW_W_CI])
                         | (m1 & s_r.tw1[`MTW_W_CI]));
            s_nxt.path = MTW_P_WIN;
            s_nxt.hold_ok = 1'b1;
          end
          else if (translation_disable_in || !s_r.tc[`MTW_TC_EN])
          begin
            s_nxt.as_n = 1'b0;
            s_nxt.path = MTW_P_PASS;
            s_nxt.hold_ok = 1'b1;
          end
          else if (!hit)
          begin
            // Abort before strobe, then search
            s_nxt.abort = 1'b1;
            s_nxt.wreq  = 1'b1;
            s_nxt.wmod  = wr_acc;
            s_nxt.wla   = acc_la;
            s_nxt.wfc   = space_code_bits;
            s_nxt.st    = MTW_WALK;
            s_nxt.path  = MTW_P_ABORT;
          end
          else if (s_r.dat[hidx][`MTW_D_B])
          begin
            s_nxt.abort = 1'b1;
            s_nxt.berr  = 1'b1;
            s_nxt.path  = MTW_P_ABORT;
          end
          else if (wr_acc && s_r.dat[hidx][`MTW_D_WP])
          begin
            s_nxt.abort = 1'b1;
            s_nxt.berr  = 1'b1;
            s_nxt.path  = MTW_P_ABORT;
          end
          else if (wr_acc && !s_r.dat[hidx][`MTW_D_M])
          begin
            s_nxt.abort = 1'b1;
            s_nxt.wreq  = 1'b1;
            s_nxt.wmod  = 1'b1;
            s_nxt.wla   = acc_la;
            s_nxt.wfc   = space_code_bits;
            s_nxt.st    = MTW_WALK;
            s_nxt.path  = MTW_P_ABORT;
          end
          else
          begin
            // Translated address, page offset untouched
            s_nxt.pa   = {(s_r.dat[hidx][23:0] & pg_mask)
                         | (acc_la[31:8] & ~pg_mask),
                          acc_la[7:0]};
            s_nxt.ci_n = ~s_r.dat[hidx][`MTW_D_CI];
            s_nxt.as_n = 1'b0;
            s_nxt.path = MTW_P_ATC;
            s_nxt.hold_ok = 1'b1;
            // Pseudo-LRU history update
            nh = s_r.hist;
            nh[hidx] = 1'b1;
            if (&nh)
            begin
              nh = '0;
              nh[hidx] = 1'b1;
            end
            s_nxt.hist = nh;
          end
          s_nxt.hold_pa = s_nxt.pa;
          s_nxt.hold_ci = ~s_nxt.ci_n;
          s_nxt.last_berr = s_nxt.berr;
        end
      end
      MTW_WALK:
      begin
        if (walk_done)
        begin
          // Victim: same tag, else free entry, else cold history
          for (int i = `MTW_ENTRIES - 1; i >= 0; i--)
            if (!s_r.hist[i])
            begin
              vic    = 5'(i);
              vfound = 1'b1;
            end
          for (int i = `MTW_ENTRIES - 1; i >= 0; i--)
            if (!s_r.tag[i][`MTW_T_V])
            begin
              vic    = 5'(i);
              vfound = 1'b1;
            end
          for (int i = `MTW_ENTRIES - 1; i >= 0; i--)
            if (whit_vec[i])
            begin
              vic    = 5'(i);
              vfound = 1'b1;
            end
          if (!vfound)
            vic = 5'h00;
          ent = {walk_berr, walk_ci, walk_wp, walk_mod, walk_pa};
          s_nxt.tag[vic] = {1'b1, s_r.wfc, s_r.wla[31:8]};
          s_nxt.dat[vic] = ent;
          nh = s_r.hist;
          nh[vic] = 1'b1;
          if (&nh)
          begin
            nh = '0;
            nh[vic] = 1'b1;
          end
          s_nxt.hist  = nh;
          s_nxt.wreq  = 1'b0;
          s_nxt.wmod  = 1'b0;
          s_nxt.retry = 1'b1;
          s_nxt.st    = MTW_IDLE;
        end
      end
    endcase

    // Synchronous reset keeps the cache contents
    if (!rst_b)
    begin
      s_nxt.tc        = `MTW_ZERO32;
      s_nxt.tw0       = `MTW_ZERO32;
      s_nxt.tw1       = `MTW_ZERO32;
      s_nxt.tag       = s_r.tag;
      s_nxt.dat       = s_r.dat;
      s_nxt.hist      = '0;
      s_nxt.st        = MTW_IDLE;
      s_nxt.wla       = `MTW_ZERO32;
      s_nxt.wfc       = 3'h0;
      s_nxt.wreq      = 1'b0;
      s_nxt.wmod      = 1'b0;
      s_nxt.hold_pa   = `MTW_ZERO32;
      s_nxt.hold_ci   = 1'b0;
      s_nxt.hold_ok   = 1'b0;
      s_nxt.rdata     = `MTW_ZERO32;
      s_nxt.pa        = `MTW_ZERO32;
      s_nxt.as_n      = 1'b1;
      s_nxt.ci_n      = 1'b1;
      s_nxt.abort     = 1'b0;
      s_nxt.berr      = 1'b0;
      s_nxt.done      = 1'b0;
      s_nxt.retry     = 1'b0;
      s_nxt.last_berr = 1'b0;
      s_nxt.path      = MTW_P_NONE;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    s_r <= s_nxt;
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Every output straight from the state register, except busy, which is decoded from its state
  assign reg_rdata           = s_r.rdata;
  assign phys_addr           = s_r.pa;
  assign address_strobe_n    = s_r.as_n;
  assign cache_inhibit_out_n = s_r.ci_n;
  assign acc_abort           = s_r.abort;
  assign acc_berr            = s_r.berr;
  assign acc_done            = s_r.done;
  assign acc_retry           = s_r.retry;
  assign busy                = (s_r.st == MTW_WALK);
  assign walk_req            = s_r.wreq;
  assign walk_la             = s_r.wla;
  assign walk_fc             = s_r.wfc;
  assign walk_set_mod        = s_r.wmod;

endmodule // mtw_top

/* shared/mtw_cfg.svh */
// Constants of the translation decision block
`ifndef MTW_CFG_SVH
`define MTW_CFG_SVH
`define MTW_ENTRIES     22
`define MTW_TAG_W       28
`define MTW_DAT_W       28
`define MTW_ADDR_W      8
// Register offsets (byte addresses)
`define MTW_OFS_TC      8'h00
`define MTW_OFS_TW0     8'h04
`define MTW_OFS_TW1     8'h08
`define MTW_OFS_STAT    8'h0C
`define MTW_OFS_CMD     8'h10
// Window register fields
`define MTW_W_BASE_HI   31
`define MTW_W_BASE_LO   24
`define MTW_W_MASK_HI   23
`define MTW_W_MASK_LO   16
`define MTW_W_EN        15
`define MTW_W_CI        10
`define MTW_W_RWSEL     9
`define MTW_W_RWM       8
`define MTW_W_FCB_HI    6
`define MTW_W_FCB_LO    4
`define MTW_W_FCM_HI    2
`define MTW_W_FCM_LO    0
// Translation control fields
`define MTW_TC_EN       31
`define MTW_TC_PS_HI    23
`define MTW_TC_PS_LO    20
`define MTW_PS_MIN      4'h8
// Command and status fields
`define MTW_CMD_FLUSH   0
`define MTW_ST_BUSY     4
`define MTW_ST_BERR     5
// Tag and entry fields
`define MTW_T_V         27
`define MTW_T_FC_HI     26
`define MTW_T_FC_LO     24
`define MTW_D_B         27
`define MTW_D_CI        26
`define MTW_D_WP        25
`define MTW_D_M         24
`define MTW_CPU_FC      3'h7
`define MTW_ZERO32      32'h0000_0000
`endif

/* shared/mtw_pkg.sv */
// Types of the translation decision block
`include "mtw_cfg.svh"
package mtw_pkg;
  typedef enum logic [0:0] {MTW_IDLE, MTW_WALK} mtw_state_t;
  typedef enum logic [2:0] {
    MTW_P_NONE, MTW_P_CPU, MTW_P_CACHE, MTW_P_WIN,
    MTW_P_PASS, MTW_P_ATC, MTW_P_ABORT, MTW_P_SEQ
  } mtw_path_t;
  typedef logic [`MTW_TAG_W-1:0] mtw_tag_t;
  typedef logic [`MTW_DAT_W-1:0] mtw_dat_t;
  typedef struct packed {
    logic [31:0]                       tc;
    logic [31:0]                       tw0;
    logic [31:0]                       tw1;
    logic [`MTW_ENTRIES-1:0][`MTW_TAG_W-1:0] tag;
    logic [`MTW_ENTRIES-1:0][`MTW_DAT_W-1:0] dat;
    logic [`MTW_ENTRIES-1:0]           hist;
    mtw_state_t                        st;
    logic [31:0]                       wla;
    logic [2:0]                        wfc;
    logic                              wreq;
    logic                              wmod;
    logic [31:0]                       hold_pa;
    logic                              hold_ci;
    logic                              hold_ok;
    logic [31:0]                       rdata;
    logic [31:0]                       pa;
    logic                              as_n;
    logic                              ci_n;
    logic                              abort;
    logic                              berr;
    logic                              done;
    logic                              retry;
    logic                              last_berr;
    mtw_path_t                         path;
  } mtw_state_s_t;
endpackage

/* verif/mtw_checker_assertions.sv */
// Checker of the translation decision answers
`timescale 1ns/1ns
module mtw_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        acc_req,
  input wire logic [31:0] acc_la,
  input wire logic [2:0]  space_code_bits,
  input wire logic        acc_read,
  input wire logic        acc_cache_hit,
  input wire logic        acc_follow,
  input wire logic        translation_disable_in,
  input wire logic [31:0] phys_addr,
  input wire logic        address_strobe_n,
  input wire logic        cache_inhibit_out_n,
  input wire logic        acc_abort,
  input wire logic        acc_berr,
  input wire logic        acc_done,
  input wire logic        acc_retry,
  input wire logic        busy,
  input wire logic        walk_req,
  input wire logic        walk_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Taken request, and its split by space code
  wire tk  = acc_req && !busy;
  wire cpu = tk && !acc_follow && space_code_bits == 3'h7;
  wire nw  = tk && !acc_follow && space_code_bits != 3'h7;
  // Answers tied to their causes
  reset_idle_a: assert property ($rose(rst_b) |-> address_strobe_n &&
    cache_inhibit_out_n && !busy && !walk_req) else $error("not idle");
  cpu_bypass_a: assert property (cpu |=> !address_strobe_n &&
    phys_addr == $past(acc_la)) else $error("space seven not passed");
  cache_done_a: assert property (nw && acc_read && acc_cache_hit |=>
    acc_done && address_strobe_n) else $error("cache hit not served");
  one_answer_a: assert property (tk |=>
    $onehot({!address_strobe_n, acc_done, acc_abort})) else $error("answers");
  abort_quiet_a: assert property (acc_abort || acc_berr |->
    acc_abort && address_strobe_n) else $error("strobe with abort");
  abort_walk_a: assert property (acc_abort && !acc_berr |->
    walk_req && busy) else $error("abort without search");
  walk_retry_a: assert property (walk_done && busy |=>
    acc_retry && !walk_req && !busy) else $error("no retry");
  dis_quiet_a: assert property (tk && translation_disable_in |=>
    !acc_abort && !walk_req) else $error("search while disabled");
  // Main scenarios reached
  cover property (acc_abort && acc_berr);
  cover property (acc_retry);
  cover property (!address_strobe_n && !cache_inhibit_out_n);
endmodule // mtw_checker
bind mtw_top mtw_checker mtw_checker_i (.*);

/* verif/mtw_walker_model.sv */
// Table walker model answering searches after a short or long delay
`timescale 1ns/1ns
module mtw_walker_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        walk_req,
  input  wire logic        m_slow,
  input  wire logic        m_berr,
  input  wire logic        m_wp,
  input  wire logic        m_mod,
  input  wire logic [23:0] m_pa,
  output logic             walk_done,
  output logic             walk_berr,
  output logic             walk_ci,
  output logic             walk_wp,
  output logic             walk_mod,
  output logic [23:0]      walk_pa
);
  logic [3:0] cnt_r;
  logic       sent_r;
  // Count while a search is pending, then pulse done once
  always_ff @(posedge clk)
  begin
    walk_done <= 1'b0;
    if (!rst_b || !walk_req)
    begin
      cnt_r  <= 4'h0;
      sent_r <= 1'b0;
    end
    else if (!sent_r)
    begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == (m_slow ? 4'hC : 4'h1))
      begin
        walk_done <= 1'b1;
        sent_r    <= 1'b1;
      end
    end
  end
  // Entry only valid with done, inverted otherwise
  assign walk_pa = walk_done ? m_pa : ~m_pa;
  assign {walk_berr, walk_wp, walk_mod} = walk_done ?
    {m_berr, m_wp, m_mod} : ~{m_berr, m_wp, m_mod};
  assign walk_ci = !walk_done;
endmodule // mtw_walker_model

/* verif/tb.sv */
// Self-checking testbench of the translation decision block
`timescale 1ns/1ns
`include "mtw_cfg.svh"
module tb;
  logic        clk, rst_b, reg_we, reg_re, acc_req, acc_read, acc_rmw;
  logic        acc_cache_hit, acc_follow, translation_disable_in, busy;
  logic        address_strobe_n, cache_inhibit_out_n, acc_abort, acc_berr;
  logic        acc_done, acc_retry, walk_req, walk_set_mod, walk_done;
  logic        walk_berr, walk_ci, walk_wp, walk_mod;
  logic        m_slow, m_berr, m_wp, m_mod;
  logic [7:0]  reg_addr;
  logic [2:0]  space_code_bits, walk_fc;
  logic [23:0] walk_pa, m_pa;
  logic [31:0] reg_wdata, reg_rdata, acc_la, phys_addr, walk_la;
  int          fails, num_checks;
  mtw_top mtw_top_i (.*);
  mtw_walker_model mtw_walker_model_i (.*);
  // Clock
  always #4 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %h %h", $time, got, exp);
    end
  endtask
  // Counts and verdict
  task automatic print_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Register write (w high) or read with expected data
  task automatic rg(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= w;
    reg_re <= !w;
    @(posedge clk);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    #1;
    if (!w)
      chk(reg_rdata, d);
  endtask
  // One access: m = read, rmw, hit, follow; k = strobe_n, done, abort, berr
  task automatic acc(input logic [31:0] la, input logic [2:0] fc,
                     input logic [3:0] m, input logic [3:0] k,
                     input logic [31:0] pa, input logic ci_n);
    int n;
    @(posedge clk);
    acc_req <= 1'b1;
    acc_la <= la;
    space_code_bits <= fc;
    {acc_read, acc_rmw, acc_cache_hit, acc_follow} <= m;
    @(posedge clk);
    acc_req <= 1'b0;
    #1;
    chk({address_strobe_n, acc_done, acc_abort, acc_berr}, k);
    if (k == 4'h0)
      chk({phys_addr, cache_inhibit_out_n}, {pa, ci_n});
    if (k == 4'hA)
    begin
      chk(walk_la, la);
      chk({busy, walk_set_mod, walk_fc}, {1'b1, ~m[3] | m[2], fc});
    end
    n = 0;
    while (k == 4'hA && acc_retry !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (k == 4'hA)
      chk(acc_retry, 1'b1);
  endtask
  // Reset state, bypass and cache hit
  task automatic t_reset();
    rg(1'b0, `MTW_OFS_TW0, `MTW_ZERO32);
    acc(32'h1234_5678, 3'h5, 4'h0, 4'h0, 32'h1234_5678, 1'b1);
    rg(1'b1, `MTW_OFS_CMD, 32'h0000_0001);
    rg(1'b1, `MTW_OFS_TC, 32'h8080_0000);
    acc(32'hFFFF_0010, 3'h7, 4'hA, 4'h0, 32'hFFFF_0010, 1'b1);
    acc(32'h0000_0020, 3'h5, 4'hA, 4'hC, `MTW_ZERO32, 1'b1);
  endtask
  // Window matching, direction, enables and inhibit
  task automatic t_win();
    rg(1'b1, `MTW_OFS_TW0, 32'h400F_8650);
    rg(1'b1, `MTW_OFS_TW1, 32'h4100_0150);
    acc(32'h4312_3456, 3'h5, 4'h8, 4'h0, 32'h4312_3456, 1'b0);
    acc(32'h4412_0000, 3'h5, 4'h0, 4'hA, `MTW_ZERO32, 1'b1);
    acc(32'h4500_0000, 3'h5, 4'hC, 4'hA, `MTW_ZERO32, 1'b1);
    m_wp <= 1'b1;
    acc(32'h4100_0008, 3'h5, 4'h0, 4'hA, `MTW_ZERO32, 1'b1);
    rg(1'b1, `MTW_OFS_TW1, 32'h4100_8150);
    acc(32'h4100_0008, 3'h5, 4'h0, 4'h0, 32'h4100_0008, 1'b1);
    acc(32'h4100_0000, 3'h5, 4'h8, 4'h0, 32'h4100_0000, 1'b0);
  endtask
  // Translation cache: bus error, protection, modified
  task automatic t_atc();
    m_berr <= 1'b1;
    m_slow <= 1'b1;
    acc(32'h0010_0000, 3'h1, 4'h8, 4'hA, `MTW_ZERO32, 1'b1);
    acc(32'h0010_0000, 3'h1, 4'h8, 4'hB, `MTW_ZERO32, 1'b1);
    rg(1'b0, `MTW_OFS_STAT, 32'h0000_0026);
    m_berr <= 1'b0;
    acc(32'h0020_0000, 3'h1, 4'h0, 4'hA, `MTW_ZERO32, 1'b1);
    acc(32'h0020_0004, 3'h1, 4'h4, 4'hB, `MTW_ZERO32, 1'b1);
    m_wp <= 1'b0;
    m_mod <= 1'b0;
    acc(32'h0030_0010, 3'h1, 4'h8, 4'hA, `MTW_ZERO32, 1'b1);
    acc(32'h0030_0010, 3'h1, 4'h8, 4'h0, 32'hABCD_EF10, 1'b1);
    m_mod <= 1'b1;
    acc(32'h0030_0010, 3'h1, 4'h0, 4'hA, `MTW_ZERO32, 1'b1);
    acc(32'h0030_0011, 3'h1, 4'h0, 4'h0, 32'hABCD_EF11, 1'b1);
  endtask
  // Translation disable with split transfer and windows
  task automatic t_dis();
    @(posedge clk);
    translation_disable_in <= 1'b1;
    acc(32'h0030_0012, 3'h1, 4'h1, 4'h0, 32'hABCD_EF12, 1'b1);
    acc(32'h0700_0004, 3'h1, 4'h0, 4'h0, 32'h0700_0004, 1'b1);
    acc(32'h4312_0000, 3'h5, 4'h8, 4'h0, 32'h4312_0000, 1'b0);
  endtask
  // Mid-run reset: enables cleared, entries kept, page size masking
  task automatic t_again();
    @(posedge clk);
    rst_b <= 1'b0;
    translation_disable_in <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rg(1'b0, `MTW_OFS_TC, `MTW_ZERO32);
    rg(1'b0, `MTW_OFS_TW0, `MTW_ZERO32);
    acc(32'h0030_0010, 3'h1, 4'h8, 4'h0, 32'h0030_0010, 1'b1);
    rg(1'b1, `MTW_OFS_TC, 32'h8090_0000);
    acc(32'h0030_0010, 3'h1, 4'h8, 4'h0, 32'hABCD_EE10, 1'b1);
    acc(32'h0030_0110, 3'h1, 4'h8, 4'h0, 32'hABCD_EF10, 1'b1);
    rg(1'b1, `MTW_OFS_CMD, 32'h0000_0001);
    acc(32'h0030_0010, 3'h1, 4'h8, 4'hA, `MTW_ZERO32, 1'b1);
  endtask
  // Reset, scenarios, verdict
  initial
  begin
    {clk, rst_b, reg_we, reg_re, acc_req, acc_read, acc_rmw} = '0;
    {acc_cache_hit, acc_follow, translation_disable_in, m_slow} = '0;
    {m_berr, m_wp, reg_addr, space_code_bits, reg_wdata, acc_la} = '0;
    m_mod = 1'b1;
    m_pa = 24'hAB_CDEF;
    fails = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_win();
    t_atc();
    t_dis();
    t_again();
    print_verdict();
  end
  // Watchdog against a hang
  initial
  begin
    #60000;
    fails++;
    print_verdict();
  end
endmodule // tb
